// ### logic/aagt_pkg.sv
// Package with the register map, field layout and timing constants of the auxiliary bank.
package aagt_pkg;

  // Register slots of the bank, in map order.
  localparam int REG_NUM = 9;
  localparam int S_CHEN  = 0;
  localparam int S_SENSE = 1;
  localparam int S_RATE  = 2;
  localparam int S_TIMER = 3;
  localparam int S_DBNC  = 4;
  localparam int S_OPTS  = 5;
  localparam int S_PINA  = 6;
  localparam int S_VOLTA = 7;
  localparam int S_PINB  = 8;

  // Register indexes; the byte address on the bus is four times the index.
  localparam logic [7:0] IDX_CONVERTER_CHANNEL_ENABLE  = 8'h82;
  localparam logic [7:0] IDX_SENSE_PIN_CURRENT_CONTROL = 8'h84;
  localparam logic [7:0] IDX_CONVERTER_RATE_SETTING    = 8'h85;
  localparam logic [7:0] IDX_TIMER_CONTROL             = 8'h8a;
  localparam logic [7:0] IDX_MONITOR_DEBOUNCE_SETTING  = 8'h8e;
  localparam logic [7:0] IDX_SHUTDOWN_RESET_OPTIONS    = 8'h8f;
  localparam logic [7:0] IDX_AUX_PIN_A_CONTROL         = 8'h90;
  localparam logic [7:0] IDX_AUX_PIN_A_VOLTAGE         = 8'h91;
  localparam logic [7:0] IDX_AUX_PIN_B_CONTROL         = 8'h92;
  localparam logic [7:0] IDX_AUX_PIN_LEVEL             = 8'h94;
  localparam int         ADDR_W                        = 10;

  localparam logic [7:0] REG_IDX [REG_NUM] = '{
    IDX_CONVERTER_CHANNEL_ENABLE, IDX_SENSE_PIN_CURRENT_CONTROL, IDX_CONVERTER_RATE_SETTING,
    IDX_TIMER_CONTROL, IDX_MONITOR_DEBOUNCE_SETTING, IDX_SHUTDOWN_RESET_OPTIONS,
    IDX_AUX_PIN_A_CONTROL, IDX_AUX_PIN_A_VOLTAGE, IDX_AUX_PIN_B_CONTROL};

  // Reset values, writable bit masks and which slots also clear on system reset.
  localparam logic [7:0] REG_RST [REG_NUM] = '{
    8'he1, 8'hf2, 8'hb0, 8'h00, 8'h40, 8'h00, 8'h07, 8'h1a, 8'h07};
  localparam logic [7:0] REG_WMASK [REG_NUM] = '{
    8'hf1, 8'hff, 8'hf7, 8'h7f, 8'hff, 8'h8f, 8'hff, 8'h1f, 8'hc7};
  localparam logic [REG_NUM-1:0] REG_SYSRST = 9'h1c8;

  // Field positions.
  localparam int F_CH_BATV   = 7;
  localparam int F_CH_BATI   = 6;
  localparam int F_CH_DIE    = 5;
  localparam int F_CH_PINA   = 4;
  localparam int F_CH_SENSE  = 0;
  localparam int F_CUR_PINA  = 6;
  localparam int F_CUR_SENSE = 4;
  localparam int F_SENSE_FN  = 2;
  localparam int F_SRC_MODE  = 0;
  localparam int F_RATE_SNS  = 6;
  localparam int F_RATE_BAT  = 4;
  localparam int F_PINA_OUT  = 2;
  localparam int F_TMO       = 7;
  localparam int F_DBNC      = 6;
  localparam int F_LONGPRESS = 3;
  localparam int F_HOT_OFF   = 2;
  localparam int F_RECOVER   = 1;
  localparam int F_RISE_EN   = 7;
  localparam int F_FALL_EN   = 6;
  localparam int F_FUNC      = 0;
  localparam int F_VOLT      = 0;

  // Pin function codes and current source modes.
  localparam logic [2:0] FN_LOW     = 3'h0;
  localparam logic [2:0] FN_HIGH    = 3'h1;
  localparam logic [2:0] FN_INPUT   = 3'h2;
  localparam logic [2:0] FN_REG_ON  = 3'h3;
  localparam logic [2:0] FN_REG_OFF = 3'h4;
  localparam logic [1:0] SRC_OFF    = 2'h0;
  localparam logic [1:0] SRC_CHARGE = 2'h1;
  localparam logic [1:0] SRC_CONV   = 2'h2;
  localparam logic [1:0] SRC_ALWAYS = 2'h3;

  // Timing: clock period, debounce step, long key press and timer tick.
  localparam longint CLK_PERIOD_NS   = 10;
  localparam longint DBNC_STEP_NS    = 62000;
  localparam longint LONG_PRESS_S    = 16;
  localparam longint TIMER_TICK_S    = 1;
  localparam longint NS_PER_S        = 1000000000;
  localparam longint DBNC_STEP_CYC   = DBNC_STEP_NS / CLK_PERIOD_NS;
  localparam longint LONG_PRESS_CYC  = LONG_PRESS_S * NS_PER_S / CLK_PERIOD_NS;
  localparam longint TIMER_TICK_CYC  = TIMER_TICK_S * NS_PER_S / CLK_PERIOD_NS;

  // Drive of one auxiliary pin.
  typedef struct packed {
    logic drive;      // Level driven out.
    logic drive_oe_n; // Low while the pin is driven.
    logic reg_en;     // Local regulator on the pin enabled.
    logic conv_in;    // Pin routed to the converter input.
    logic dig_in;     // Pin used as digital input.
  } aagt_pin_ctl_t;

endpackage : aagt_pkg

// ### logic/aagt_edge_det.sv
// Edge detector and level sampler for one auxiliary pin in digital input mode.
`timescale 1ns/10ps
`default_nettype none
module aagt_edge_det (
  // Clock and reset.
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic ce,
  input  wire logic sys_reset,
  // Pin and configuration.
  input  wire logic pin_in,
  input  wire logic in_mode,
  input  wire logic rise_en,
  input  wire logic fall_en,
  // Results.
  output logic      event_q,
  output logic      level_q
);

  logic prev_q;
  wire  rise_hit = rise_en & pin_in & ~prev_q;
  wire  fall_hit = fall_en & ~pin_in & prev_q;

  // Edges count only while the pin is a digital input; otherwise the level holds until a system reset clears it.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_q  <= 1'b0;
      event_q <= 1'b0;
      level_q <= 1'b0;
    end else if (ce) begin
      prev_q  <= pin_in;
      event_q <= in_mode & (rise_hit | fall_hit);
      if (sys_reset) begin
        level_q <= 1'b0;
      end else if (in_mode) begin
        level_q <= pin_in;
      end
    end
  end

endmodule : aagt_edge_det
`default_nettype wire

// ### logic/aagt_regs.sv
// Auxiliary converter, timer, monitor, option and pin control register bank with APB access.
//
// Overview of operation
// RULE_01 - Five channel enables, auxiliary channel off at reset.
// RULE_02 - Pin current codes 20 to 80uA, default 11.
// RULE_03 - Sense pin: battery temperature or plain converter input.
// RULE_04 - Sense source: off, charging, conversion, always on.
// RULE_05 - Sense/auxiliary rate 25 to 200 Hz, default 10.
// RULE_06 - Battery rate 100 to 800 Hz, default 11.
// RULE_07 - Work-mode bit drives current out of pin A.
// RULE_08 - Zero timer threshold disables timer; system reset clears.
// RULE_09 - Timeout sets status; writing one clears, restarts timer.
// RULE_10 - Monitor debounce 62 to 248us, default 124us.
// RULE_11 - Sixteen-second key press resets when enabled.
// RULE_12 - Optional shutdown on die temperature warning.
// RULE_13 - Recovery bit keeps or restores wake voltages.
// RULE_14 - Pin A edge enables raise wake events.
// RULE_15 - Pin A three-bit function code, default floating.
// RULE_16 - Pin A voltage code, 100 mV steps, default 11010.
// RULE_17 - Pin B edge enables raise wake events.
// RULE_18 - Pin B function code, floating without converter option.
// RULE_19 - Read-only register reports both pin input levels.
// RULE_20 - Timeout and pin edges reach the event output.
//
// Our own choice: the APB slave port.
`timescale 1ns/10ps
`default_nettype none
module aagt_regs
  import aagt_pkg::*;
#(
  parameter int unsigned DBNC_STEP_CYCLES  = 32'(DBNC_STEP_CYC),
  parameter int unsigned LONG_PRESS_CYCLES = 32'(LONG_PRESS_CYC),
  parameter int unsigned TIMER_TICK_CYCLES = 32'(TIMER_TICK_CYC)
) (
  // Clock, reset and clock enable.
  input  wire logic          pclk,
  input  wire logic          presetn,
  input  wire logic          ce,
  input  wire logic          sys_reset,
  // APB slave.
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [11:0]   paddr,
  input  wire logic [31:0]   pwdata,
  input  wire logic [3:0]    pstrb,
  output logic      [31:0]   prdata,
  output logic               pready,
  output logic               pslverr,
  // Device status inputs.
  input  wire logic          charging,
  input  wire logic          conv_phase,
  input  wire logic          mon_fault_raw,
  input  wire logic          power_key_held,
  input  wire logic          die_temp_warn,
  input  wire logic          aux_pin_a_in,
  input  wire logic          aux_pin_b_in,
  // Converter and sense controls.
  output logic      [4:0]    chan_enable,
  output logic      [1:0]    aux_pin_a_cur_code,
  output logic      [1:0]    temp_sense_pin_cur_code,
  output logic               temp_sense_pin_conv_mode,
  output logic               temp_sense_pin_src_on,
  output logic      [1:0]    sense_rate_code,
  output logic      [1:0]    battery_rate_code,
  output logic               aux_pin_a_src_on,
  // Monitor, reset and shutdown controls.
  output logic               mon_fault,
  output logic               por_request,
  output logic               shutdown_request,
  output logic               keep_voltage_on_wake,
  // Pin drive and events.
  output aagt_pin_ctl_t      aux_pin_a_ctl,
  output aagt_pin_ctl_t      aux_pin_b_ctl,
  output logic      [4:0]    aux_pin_a_voltage_code,
  output logic               event_irq,
  output logic               timer_timeout
);

  // Pin function decode, shared by both pins; only pin A offers the converter input.
  function automatic aagt_pin_ctl_t pin_decode(input logic [2:0] code, input logic conv_ok);
    aagt_pin_ctl_t c;
    c.drive      = (code == FN_HIGH);
    c.drive_oe_n = !((code == FN_LOW) || (code == FN_HIGH));
    c.reg_en     = (code == FN_REG_ON);
    c.dig_in     = (code == FN_INPUT);
    c.conv_in    = (code > FN_REG_OFF) & conv_ok;
    return c;
  endfunction : pin_decode

  // Pin drive after reset: nothing driven, every use off.
  localparam aagt_pin_ctl_t PIN_IDLE = '{drive: 1'b0, drive_oe_n: 1'b1, reg_en: 1'b0,
    conv_in: 1'b0, dig_in: 1'b0};

  logic [7:0]  regs_q [REG_NUM];
  logic        tmo_q;
  logic        pready_q;
  logic [31:0] prdata_q;
  logic        pslverr_q;
  logic [31:0] tick_cnt_q;
  logic [6:0]  tmr_cnt_q;
  logic [31:0] dbnc_cnt_q;
  logic [31:0] key_cnt_q;
  logic        key_fired_q;
  logic        por_q;
  logic        mon_q;
  logic        shut_q;
  logic        src_on_q;
  logic        evt_q;
  aagt_pin_ctl_t pa_q;
  aagt_pin_ctl_t pb_q;
  logic        ev_a;
  logic        ev_b;
  logic        lvl_a;
  logic        lvl_b;

  // Bus decode: the index is the word address; byte lane 0 carries the register.
  wire         access   = psel & penable & ce;
  wire         commit   = access & pready_q;
  wire         wr_ok    = commit & pwrite & pstrb[0];
  wire [9:0]   word_idx = paddr[11:2];
  wire         hit_lvl  = (word_idx == {2'b00, IDX_AUX_PIN_LEVEL});
  logic [REG_NUM-1:0] hit;
  logic [7:0]  rd_byte;

  // Fields used by the block's own logic.
  wire [6:0] tmr_thr    = regs_q[S_TIMER][6:0];
  wire [1:0] src_mode   = regs_q[S_SENSE][F_SRC_MODE +: 2];
  wire [1:0] dbnc_code  = regs_q[S_DBNC][F_DBNC +: 2];
  wire [2:0] pa_func    = regs_q[S_PINA][F_FUNC +: 3];
  wire [2:0] pb_func    = regs_q[S_PINB][F_FUNC +: 3];
  wire       pa_chan_on = regs_q[S_CHEN][F_CH_PINA];

  genvar gi;
  generate
    for (gi = 0; gi < REG_NUM; gi++) begin : g_reg
      assign hit[gi] = (word_idx == {2'b00, REG_IDX[gi]});
      // Writable bits load on the access edge; power-on and system reset per slot.
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          regs_q[gi] <= REG_RST[gi];
        end else if (ce) begin
          if (sys_reset && REG_SYSRST[gi]) begin
            regs_q[gi] <= REG_RST[gi]; // RULE_08
          end else if (wr_ok && hit[gi]) begin
            regs_q[gi] <= (pwdata[7:0] & REG_WMASK[gi]) | (regs_q[gi] & ~REG_WMASK[gi]);
          end
        end
      end
    end
  endgenerate

  // Read mux; the timeout flag lives outside the array and the level register is read-only.
  always_comb begin
    rd_byte = 8'h00;
    for (int i = 0; i < REG_NUM; i++) begin
      if (hit[i]) begin
        rd_byte = regs_q[i] & REG_WMASK[i];
      end
    end
    if (hit[S_TIMER]) begin
      rd_byte[F_TMO] = tmo_q;
    end
    if (hit_lvl) begin
      rd_byte = {6'h00, lvl_b, lvl_a}; // RULE_19
    end
  end

  // Unmapped words read as zero and answer with an error.
  wire mapped = (|hit) | hit_lvl;

  // One wait state: ready rises on the first access cycle and the transfer ends on the next.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      prdata_q  <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else if (ce) begin
      pready_q  <= access & ~pready_q;
      pslverr_q <= access & ~pready_q & ~mapped;
      if (access && !pready_q) begin
        prdata_q <= {24'h00_0000, rd_byte};
      end
    end
  end

  // Timer: prescaler gives ticks, ticks count up to the threshold.
  wire tmr_on   = (tmr_thr != 7'h00); // RULE_08
  wire tick     = (tick_cnt_q == TIMER_TICK_CYCLES - 32'h0000_0001);
  wire tmo_hit  = tmr_on & tick & (tmr_cnt_q + 7'h01 >= tmr_thr);
  wire tmo_clr  = wr_ok & hit[S_TIMER] & pwdata[F_TMO];
  wire tmr_stop = ~tmr_on | tmo_clr | sys_reset;

  // A clear that lands with a new timeout loses: the timeout is kept.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt_q <= 32'h0000_0000;
      tmr_cnt_q  <= 7'h00;
      tmo_q      <= 1'b0;
    end else if (ce) begin
      if (tmr_stop || tmo_hit || tick) begin
        tick_cnt_q <= 32'h0000_0000; // RULE_09
      end else begin
        tick_cnt_q <= tick_cnt_q + 32'h0000_0001;
      end
      if (tmr_stop || tmo_hit) begin
        tmr_cnt_q <= 7'h00;
      end else if (tick) begin
        tmr_cnt_q <= tmr_cnt_q + 7'h01;
      end
      if (tmo_hit) begin
        tmo_q <= 1'b1; // RULE_09
      end else if (tmo_clr || sys_reset) begin
        tmo_q <= 1'b0; // RULE_09
      end
    end
  end

  // Monitor debounce: the raw level must differ for the whole window before it is taken.
  wire [31:0] dbnc_limit = DBNC_STEP_CYCLES * ({30'h0000_0000, dbnc_code} + 32'h0000_0001);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dbnc_cnt_q <= 32'h0000_0000;
      mon_q      <= 1'b0;
    end else if (ce) begin
      if (mon_fault_raw == mon_q) begin
        dbnc_cnt_q <= 32'h0000_0000;
      end else if (dbnc_cnt_q >= dbnc_limit - 32'h0000_0001) begin
        dbnc_cnt_q <= 32'h0000_0000;
        mon_q      <= mon_fault_raw; // RULE_10
      end else begin
        dbnc_cnt_q <= dbnc_cnt_q + 32'h0000_0001;
      end
    end
  end

  // Long key press: one request per press, held key does not repeat it.
  // The reset request is one pulse; downstream logic must hold it.
  wire key_en = regs_q[S_OPTS][F_LONGPRESS];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      key_cnt_q   <= 32'h0000_0000;
      key_fired_q <= 1'b0;
      por_q       <= 1'b0;
    end else if (ce) begin
      por_q <= 1'b0;
      if (!power_key_held || !key_en) begin
        key_cnt_q   <= 32'h0000_0000;
        key_fired_q <= 1'b0;
      end else if (!key_fired_q) begin
        if (key_cnt_q == LONG_PRESS_CYCLES - 32'h0000_0001) begin
          key_fired_q <= 1'b1;
          por_q       <= 1'b1; // RULE_11
        end else begin
          key_cnt_q <= key_cnt_q + 32'h0000_0001;
        end
      end
    end
  end

  // Sense current source by mode.
  logic src_on_d;
  always_comb begin
    case (src_mode)
      SRC_OFF:    src_on_d = 1'b0; // RULE_04
      SRC_CHARGE: src_on_d = charging;
      SRC_CONV:   src_on_d = conv_phase;
      SRC_ALWAYS: src_on_d = 1'b1;
      default:    src_on_d = 1'b0;
    endcase
  end

  // Registered derived controls so every output leaves from a flip-flop.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shut_q   <= 1'b0;
      src_on_q <= 1'b0;
      evt_q    <= 1'b0;
      pa_q     <= PIN_IDLE;
      pb_q     <= PIN_IDLE;
    end else if (ce) begin
      shut_q   <= die_temp_warn & regs_q[S_OPTS][F_HOT_OFF]; // RULE_12
      src_on_q <= src_on_d;
      evt_q    <= tmo_hit | ev_a | ev_b; // RULE_20
      pa_q     <= pin_decode(pa_func, pa_chan_on); // RULE_15
      pb_q     <= pin_decode(pb_func, 1'b0); // RULE_18
    end
  end

  // Edge events and levels of the two pins.
  aagt_edge_det u_edge_a (
    .pclk      (pclk),
    .presetn   (presetn),
    .ce        (ce),
    .sys_reset (sys_reset),
    .pin_in    (aux_pin_a_in),
    .in_mode   (pa_q.dig_in),
    .rise_en   (regs_q[S_PINA][F_RISE_EN]), // RULE_14
    .fall_en   (regs_q[S_PINA][F_FALL_EN]), // RULE_14
    .event_q   (ev_a),
    .level_q   (lvl_a)
  );

  aagt_edge_det u_edge_b (
    .pclk      (pclk),
    .presetn   (presetn),
    .ce        (ce),
    .sys_reset (sys_reset),
    .pin_in    (aux_pin_b_in),
    .in_mode   (pb_q.dig_in),
    .rise_en   (regs_q[S_PINB][F_RISE_EN]), // RULE_17
    .fall_en   (regs_q[S_PINB][F_FALL_EN]), // RULE_17
    .event_q   (ev_b),
    .level_q   (lvl_b)
  );

  // Outputs straight from the register flops.
  assign prdata    = prdata_q;
  assign pready    = pready_q;
  assign pslverr   = pslverr_q;
  assign chan_enable = {regs_q[S_CHEN][F_CH_BATV], regs_q[S_CHEN][F_CH_BATI],
                        regs_q[S_CHEN][F_CH_DIE], regs_q[S_CHEN][F_CH_PINA],
                        regs_q[S_CHEN][F_CH_SENSE]}; // RULE_01
  assign aux_pin_a_cur_code       = regs_q[S_SENSE][F_CUR_PINA +: 2]; // RULE_02
  assign temp_sense_pin_cur_code  = regs_q[S_SENSE][F_CUR_SENSE +: 2]; // RULE_02
  assign temp_sense_pin_conv_mode = regs_q[S_SENSE][F_SENSE_FN]; // RULE_03
  assign temp_sense_pin_src_on    = src_on_q; // RULE_04
  assign sense_rate_code          = regs_q[S_RATE][F_RATE_SNS +: 2]; // RULE_05
  assign battery_rate_code        = regs_q[S_RATE][F_RATE_BAT +: 2]; // RULE_06
  assign aux_pin_a_src_on         = regs_q[S_RATE][F_PINA_OUT]; // RULE_07
  assign mon_fault                = mon_q;
  assign por_request              = por_q;
  assign shutdown_request         = shut_q;
  assign keep_voltage_on_wake     = regs_q[S_OPTS][F_RECOVER]; // RULE_13
  assign aux_pin_a_ctl            = pa_q;
  assign aux_pin_b_ctl            = pb_q;
  assign aux_pin_a_voltage_code   = regs_q[S_VOLTA][F_VOLT +: 5]; // RULE_16
  assign event_irq                = evt_q;
  assign timer_timeout            = tmo_q;

endmodule : aagt_regs
`default_nettype wire

// ### bench/aagt_regs_asserts.sv
// Checker for the port behaviour of the auxiliary register bank.
`timescale 1ns/10ps
`default_nettype none
module aagt_regs_chk
  import aagt_pkg::*;
(
  // Clock and reset.
  input wire logic          pclk,
  input wire logic          presetn,
  // Bus and status inputs.
  input wire logic          psel,
  input wire logic          penable,
  input wire logic          pwrite,
  input wire logic [11:0]   paddr,
  input wire logic [31:0]   pwdata,
  input wire logic          pready,
  input wire logic          pslverr,
  input wire logic          ce,
  input wire logic          sys_reset,
  input wire logic          die_temp_warn,
  input wire logic          power_key_held,
  // Watched outputs.
  input wire logic [4:0]    chan_enable,
  input wire logic          shutdown_request,
  input wire logic          por_request,
  input wire logic          event_irq,
  input wire logic          timer_timeout,
  input wire aagt_pin_ctl_t aux_pin_a_ctl,
  input wire aagt_pin_ctl_t aux_pin_b_ctl
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // A taken write of one to the timeout bit; a clear may only follow this or a system reset.
  wire logic clr_wr;
  assign clr_wr = psel & penable & pwrite & pready & (paddr == 12'h228) & pwdata[7];
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready held beyond one cycle");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("error flag without ready");
  a_timeout_irq: assert property ($rose(timer_timeout) |->
    event_irq || $past(event_irq))
    else $error("timeout without event pulse");
  a_timeout_clear: assert property ($fell(timer_timeout) |->
    $past(clr_wr) || $past(sys_reset))
    else $error("timeout cleared without cause");
  a_hot_off: assert property ($past(ce) && !$past(die_temp_warn) |-> !shutdown_request)
    else $error("shutdown without warning");
  a_por_key: assert property (por_request |-> $past(power_key_held))
    else $error("reset request without key");
  a_pin_a_excl: assert property ($onehot0({!aux_pin_a_ctl.drive_oe_n,
    aux_pin_a_ctl.reg_en, aux_pin_a_ctl.conv_in, aux_pin_a_ctl.dig_in}))
    else $error("pin a uses overlap");
  a_pin_a_conv: assert property (aux_pin_a_ctl.conv_in |->
    chan_enable[1] || $past(chan_enable[1]))
    else $error("pin a converter input with channel off");
  a_pin_b_float: assert property (!aux_pin_b_ctl.conv_in)
    else $error("pin b routed to converter");
  // Main scenarios reached.
  c_timeout: cover property ($rose(timer_timeout));
  c_por: cover property (por_request);
  c_err: cover property (pslverr);
  c_irq: cover property (event_irq);
endmodule : aagt_regs_chk

bind aagt_regs aagt_regs_chk i_aagt_regs_chk (.pclk, .presetn, .psel, .penable, .pwrite,
  .paddr, .pwdata, .pready, .pslverr, .ce, .sys_reset, .die_temp_warn, .power_key_held,
  .chan_enable, .shutdown_request, .por_request, .event_irq, .timer_timeout, .aux_pin_a_ctl,
  .aux_pin_b_ctl);
`default_nettype wire

// ### bench/aagt_regs_tb.sv
// Self-checking bench for the auxiliary register bank.
`timescale 1ns/10ps
`default_nettype none
module aagt_regs_tb;
  import aagt_pkg::*;
  // Shortened counts so the run stays short.
  localparam int TICK = 5;
  localparam int DB   = 4;
  localparam int LP   = 20;
  // Bench-driven inputs.
  logic pclk = 0, presetn = 0, ce = 1, sys_reset = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic charging = 0, conv_phase = 0, mon_fault_raw = 0, power_key_held = 0;
  logic die_temp_warn = 0, aux_pin_a_in = 0, aux_pin_b_in = 0;
  // Observed outputs.
  logic [31:0] prdata;
  logic pready, pslverr, temp_sense_pin_conv_mode, temp_sense_pin_src_on, aux_pin_a_src_on;
  logic mon_fault, por_request, shutdown_request, keep_voltage_on_wake, event_irq;
  logic timer_timeout;
  logic [4:0] chan_enable, aux_pin_a_voltage_code;
  logic [1:0] aux_pin_a_cur_code, temp_sense_pin_cur_code, sense_rate_code, battery_rate_code;
  aagt_pin_ctl_t aux_pin_a_ctl, aux_pin_b_ctl;
  int failures = 0, n_compared = 0, n;
  logic [7:0] rd;
  logic err;

  aagt_regs #(.DBNC_STEP_CYCLES(DB), .LONG_PRESS_CYCLES(LP), .TIMER_TICK_CYCLES(TICK))
  i_aagt_regs (.pclk, .presetn, .ce, .sys_reset, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pstrb(4'hf), .prdata, .pready, .pslverr, .charging, .conv_phase, .mon_fault_raw,
    .power_key_held, .die_temp_warn, .aux_pin_a_in, .aux_pin_b_in, .chan_enable,
    .aux_pin_a_cur_code, .temp_sense_pin_cur_code, .temp_sense_pin_conv_mode,
    .temp_sense_pin_src_on, .sense_rate_code, .battery_rate_code, .aux_pin_a_src_on,
    .mon_fault, .por_request, .shutdown_request, .keep_voltage_on_wake, .aux_pin_a_ctl,
    .aux_pin_b_ctl, .aux_pin_a_voltage_code, .event_irq, .timer_timeout);

  // Free-running clock.
  always #5 pclk = ~pclk;

  // Verdict and end of run.
  task automatic finish_test();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : finish_test

  // One comparison, counted.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Bounded wait for a level; a required level that never comes ends the run.
  task automatic await(ref logic s, input logic v, input int lim, input bit must, output int k);
    k = 0;
    while (s !== v && k < lim) begin
      @(posedge pclk);
      k++;
    end
    if (must && s !== v) begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, s, v);
      finish_test();
    end
  endtask : await

  // One bus transfer; signals held until ready is sampled high at an edge.
  task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] wd);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= {24'h00_0000, wd};
    @(posedge pclk);
    penable <= 1'b1;
    await(pready, 1'b1, 20, 1'b1, k);
    rd = prdata[7:0];
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Read one register and compare.
  task automatic rchk(input logic [7:0] idx, input logic [7:0] exp);
    apb(1'b0, idx, 8'h00);
    chk(rd, exp);
  endtask : rchk

  // Let a register change reach the registered outputs.
  task automatic settle();
    repeat (2) @(posedge pclk);
  endtask : settle

  // Hang guard.
  initial begin
    repeat (20000) @(posedge pclk);
    failures++;
    finish_test();
  end

  // Main sequence.
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < REG_NUM; i++) begin
      rchk(REG_IDX[i], REG_RST[i]);
    end
    rchk(IDX_AUX_PIN_LEVEL, 8'h00);
    chk(chan_enable, 5'h1d);
    chk({aux_pin_a_cur_code, temp_sense_pin_cur_code}, 4'hf);
    chk({sense_rate_code, battery_rate_code, aux_pin_a_voltage_code},
      9'h17a);
    $display("test reset_values done");
    // All ones then all zeros; only writable bits stick.
    for (int i = 0; i < REG_NUM; i++) begin
      apb(1'b1, REG_IDX[i], 8'hff);
      rchk(REG_IDX[i], REG_WMASK[i]);
    end
    settle();
    chk(aux_pin_a_ctl, 5'h0a);
    chk({aux_pin_a_src_on, temp_sense_pin_conv_mode, keep_voltage_on_wake},
      3'h7);
    for (int i = 0; i < REG_NUM; i++) begin
      apb(1'b1, REG_IDX[i], 8'h00);
    end
    apb(1'b1, IDX_AUX_PIN_B_CONTROL, 8'h01);
    settle();
    chk({chan_enable, aux_pin_a_src_on, temp_sense_pin_conv_mode}, 7'h00);
    chk({aux_pin_a_ctl, aux_pin_b_ctl}, 10'h010);
    apb(1'b0, 8'h83, 8'h00);
    chk({err, rd}, 9'h100);
    apb(1'b1, IDX_AUX_PIN_LEVEL, 8'hff);
    rchk(IDX_AUX_PIN_LEVEL, 8'h00);
    $display("test access done");
    // Current source against each mode and each charger and phase state.
    for (int m = 0; m < 4; m++) begin
      apb(1'b1, IDX_SENSE_PIN_CURRENT_CONTROL, m[7:0]);
      for (int c = 0; c < 4; c++) begin
        charging <= c[0];
        conv_phase <= c[1];
        settle();
        chk(temp_sense_pin_src_on, m == 3 || (m == 1 && c[0]) || (m == 2 && c[1]));
      end
    end
    $display("test source_modes done");
    // Pin edges: only enabled edges raise an event; levels read back.
    apb(1'b1, IDX_AUX_PIN_A_CONTROL, 8'h82);
    apb(1'b1, IDX_AUX_PIN_B_CONTROL, 8'h42);
    aux_pin_b_in <= 1'b1;
    await(event_irq, 1'b1, 6, 1'b0, n);
    chk(event_irq, 1'b0);
    chk(aux_pin_a_ctl, 5'h09);
    aux_pin_a_in <= 1'b1;
    await(event_irq, 1'b1, 6, 1'b1, n);
    rchk(IDX_AUX_PIN_LEVEL, 8'h03);
    aux_pin_a_in <= 1'b0;
    await(event_irq, 1'b1, 6, 1'b0, n);
    chk(event_irq, 1'b0);
    aux_pin_b_in <= 1'b0;
    await(event_irq, 1'b1, 6, 1'b1, n);
    $display("test pin_edges done");
    // Timer: expiry, clear by writing one, zero threshold, system reset.
    apb(1'b1, IDX_TIMER_CONTROL, 8'h02);
    await(timer_timeout, 1'b1, 4 * TICK + 10, 1'b1, n);
    chk(n >= 2 * TICK - 2 && n <= 2 * TICK + 4, 1'b1);
    rchk(IDX_TIMER_CONTROL, 8'h82);
    apb(1'b1, IDX_TIMER_CONTROL, 8'h80);
    rchk(IDX_TIMER_CONTROL, 8'h00);
    await(timer_timeout, 1'b1, 4 * TICK, 1'b0, n);
    chk(timer_timeout, 1'b0);
    apb(1'b1, IDX_TIMER_CONTROL, 8'h05);
    sys_reset <= 1'b1;
    @(posedge pclk);
    sys_reset <= 1'b0;
    rchk(IDX_TIMER_CONTROL, 8'h00);
    rchk(IDX_AUX_PIN_A_CONTROL, 8'h07);
    rchk(IDX_MONITOR_DEBOUNCE_SETTING, 8'h00);
    $display("test timer done");
    // Debounce at code 01 behind a clock-enable pause, then code 11.
    apb(1'b1, IDX_MONITOR_DEBOUNCE_SETTING, 8'h40);
    mon_fault_raw <= 1'b1;
    ce <= 1'b0;
    repeat (5) @(posedge pclk);
    ce <= 1'b1;
    await(mon_fault, 1'b1, 40, 1'b1, n);
    chk(n >= 2 * DB && n <= 2 * DB + 3, 1'b1);
    apb(1'b1, IDX_MONITOR_DEBOUNCE_SETTING, 8'hc0);
    mon_fault_raw <= 1'b0;
    await(mon_fault, 1'b0, 40, 1'b1, n);
    chk(n >= 4 * DB && n <= 4 * DB + 3, 1'b1);
    $display("test debounce done");
    // Long key press and hot shutdown, enabled then disabled.
    apb(1'b1, IDX_SHUTDOWN_RESET_OPTIONS, 8'h0e);
    settle();
    chk(keep_voltage_on_wake, 1'b1);
    power_key_held <= 1'b1;
    await(por_request, 1'b1, 40, 1'b1, n);
    chk(n >= LP && n <= LP + 3, 1'b1);
    die_temp_warn <= 1'b1;
    settle();
    chk(shutdown_request, 1'b1);
    apb(1'b1, IDX_SHUTDOWN_RESET_OPTIONS, 8'h00);
    await(por_request, 1'b1, 2 * LP + 5, 1'b0, n);
    chk({por_request, shutdown_request}, 2'h0);
    power_key_held <= 1'b0;
    die_temp_warn <= 1'b0;
    $display("test options done");
    finish_test();
  end
endmodule : aagt_regs_tb
`default_nettype wire
